// >>> rsp_pkg.sv
// Package of constants and carrier types for the reset, suspend and power-select block.
// Operation
// R1: Drive two main card supply select outputs.
// R2: Drive two programming supply select outputs.
// R3: Global reset floats outputs, clears every register.
// R4: Under global reset, sit in default condition.
// R5: System asserts global reset only at boot; the model also asserts it with every bus reset when tied.
// R6: System uses bus reset after boot.
// R7: Without wake need, tie both resets together.
// R8: Suspend shields registers from global reset, floats outputs.
// R9: Suspend shields registers from bus reset, floats outputs.
// R10: Bus clock rising edge samples all inputs.
// R11: Bus reset floats outputs, clears bus-resettable registers.
// R12: During bus reset, perform no function.
// R13: After bus reset release, start from default.
`default_nettype none
package rsp_pkg;

  // Depth of the pin synchronisers.
  localparam int unsigned RSP_SYNC_STAGES = 2;

  // Select pair for the two card rails.
  typedef struct packed {
    logic [1:0] card;
    logic [1:0] prog;
  } rsp_sel_t;

  // Default select value: both rails off.
  localparam rsp_sel_t RSP_SEL_RST = 4'h0;

  // Reset value of the retained wake context.
  localparam logic RSP_PME_RST = 1'h0;

  // Operating condition of the block.
  typedef enum logic [1:0] {
    RSP_RUN,
    RSP_BUS_RST,
    RSP_GLB_RST,
    RSP_SUSPEND
  } rsp_mode_t;

endpackage
`default_nettype wire

// >>> rsp_sync.sv
// Multi-bit two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module rsp_sync
  import rsp_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// >>> rsp_ctl.sv
// Reset, suspend protection and card power-switch select control.
`timescale 1ns/1ps
`default_nettype none
module rsp_ctl
  import rsp_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     global_reset_in,
  input  wire logic     host_bus_reset_in,
  input  wire logic     suspend_in,
  input  wire logic     pme_event_in,
  input  wire logic     sel_req_valid,
  input  wire rsp_sel_t sel_req,
  output var  logic     card_supply_sel0,
  output var  logic     card_supply_sel1,
  output var  logic     prog_supply_sel0,
  output var  logic     prog_supply_sel1,
  output var  logic     supply_sel_oe,
  output var  logic     pme_context,
  output var  logic     pme_context_oe,
  output var  logic     running
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [2:0] pins_s;
  logic       glb_s;
  logic       bus_s;
  logic       susp_s;

  // The reset and suspend pins are sampled on the rising bus clock edge through two stages.
  rsp_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({global_reset_in, host_bus_reset_in, suspend_in}),
    .dout (pins_s)
  ); // R10

  assign glb_s  = pins_s[2];
  assign bus_s  = pins_s[1];
  assign susp_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Operating condition

  rsp_mode_t mode_ff;
  rsp_mode_t nxt_mode;
  rsp_sel_t  sel_ff;
  logic      pme_ff;
  logic      oe_ff;
  logic      run_ff;

  // Suspend outranks both resets; global reset outranks bus reset.
  always_comb begin
    if (susp_s) begin
      nxt_mode = RSP_SUSPEND; // R8 R9
    end else if (glb_s) begin
      nxt_mode = RSP_GLB_RST; // R4
    end else if (bus_s) begin
      nxt_mode = RSP_BUS_RST; // R12
    end else begin
      nxt_mode = RSP_RUN;
    end
  end

  // Condition register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= RSP_GLB_RST;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-switch selects

  // Selects load only when running; either reset clears them unless suspended.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_ff <= RSP_SEL_RST;
    end else if (nxt_mode == RSP_GLB_RST || nxt_mode == RSP_BUS_RST) begin
      sel_ff <= RSP_SEL_RST; // R3 R11 R13
    end else if (nxt_mode == RSP_RUN && sel_req_valid) begin
      sel_ff <= sel_req; // R1 R2
    end
  end

  assign card_supply_sel0 = sel_ff.card[0]; // R1
  assign card_supply_sel1 = sel_ff.card[1]; // R1
  assign prog_supply_sel0 = sel_ff.prog[0]; // R2
  assign prog_supply_sel1 = sel_ff.prog[1]; // R2

  ////////////////////////////////////////////////////////////////////////////////
  // Wake context kept across bus reset

  // Only an unshielded global reset clears the wake context; bus reset keeps it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pme_ff <= RSP_PME_RST;
    end else if (nxt_mode == RSP_GLB_RST) begin
      pme_ff <= RSP_PME_RST; // R3
    end else if (nxt_mode == RSP_RUN && pme_event_in) begin
      pme_ff <= 1'h1;
    end
  end

  assign pme_context = pme_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Output enables

  // Pins float in every condition except running.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_ff  <= 1'h0;
      run_ff <= 1'h0;
    end else begin
      oe_ff  <= (nxt_mode == RSP_RUN); // R3 R8 R9 R11
      run_ff <= (nxt_mode == RSP_RUN); // R12 R13
    end
  end

  assign supply_sel_oe  = oe_ff;
  assign pme_context_oe = oe_ff;
  assign running        = run_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_main_rail_load: assert property (@(posedge clk) disable iff (rst) // R1
    sel_req_valid && !glb_s && !bus_s && !susp_s |=> sel_ff.card == $past(sel_req.card))
    else $error("Main rail select did not load.");

  a_prog_rail_load: assert property (@(posedge clk) disable iff (rst) // R2
    sel_req_valid && !glb_s && !bus_s && !susp_s |=> sel_ff.prog == $past(sel_req.prog))
    else $error("Programming rail select did not load.");

  a_glb_clears_all: assert property (@(posedge clk) disable iff (rst) // R3
    glb_s && !susp_s |=> !oe_ff && sel_ff == RSP_SEL_RST && pme_ff == RSP_PME_RST)
    else $error("Global reset left state or drive.");

  a_glb_default_mode: assert property (@(posedge clk) disable iff (rst) // R4
    (glb_s && !susp_s)[*2] |=> mode_ff == RSP_GLB_RST && !run_ff)
    else $error("Global reset not in default condition.");

  a_susp_hold_glb: assert property (@(posedge clk) disable iff (rst) // R8
    susp_s && glb_s |=> $stable(sel_ff) && $stable(pme_ff) && !oe_ff)
    else $error("Suspend did not shield from global reset.");

  a_susp_hold_bus: assert property (@(posedge clk) disable iff (rst) // R9
    susp_s && bus_s |=> $stable(sel_ff) && $stable(pme_ff) && !pme_context_oe)
    else $error("Suspend did not shield from bus reset.");

  a_pin_two_edges: assert property (@(posedge clk) disable iff (rst) // R10
    ##2 bus_s == $past(host_bus_reset_in, 2))
    else $error("Bus reset pin not sampled through two stages.");

  a_bus_clears_sel: assert property (@(posedge clk) disable iff (rst) // R11
    bus_s && !glb_s && !susp_s |=> !oe_ff && sel_ff == RSP_SEL_RST && $stable(pme_ff))
    else $error("Bus reset did not float and clear.");

  a_bus_no_func: assert property (@(posedge clk) disable iff (rst) // R12
    bus_s && !susp_s && sel_req_valid |=> !run_ff && sel_ff == RSP_SEL_RST)
    else $error("Function performed during bus reset.");

  a_bus_release: assert property (@(posedge clk) disable iff (rst) // R13
    $fell(bus_s) && !glb_s && !susp_s && !sel_req_valid
      |=> run_ff && oe_ff && sel_ff == RSP_SEL_RST)
    else $error("Bus reset release not from default.");

  // The global reset and suspend pins reach the logic after the same two stages as bus reset.
  a_glb_pin_sync: assert property (@(posedge clk) disable iff (rst) // R10
    ##2 glb_s == $past(global_reset_in, RSP_SYNC_STAGES))
    else $error("Global reset pin not sampled through two stages.");

  a_susp_pin_sync: assert property (@(posedge clk) disable iff (rst) // R10
    ##2 susp_s == $past(suspend_in, RSP_SYNC_STAGES))
    else $error("Suspend pin not sampled through two stages.");

  // Any reset or suspend floats the pins and stops operation on the next edge.
  a_glb_floats: assert property (@(posedge clk) disable iff (rst) // R3
    glb_s |=> !oe_ff && !run_ff)
    else $error("Global reset left pins driven.");

  a_bus_floats: assert property (@(posedge clk) disable iff (rst) // R11
    bus_s |=> !oe_ff && !run_ff)
    else $error("Bus reset left pins driven.");

  a_susp_floats: assert property (@(posedge clk) disable iff (rst) // R8
    susp_s |=> !oe_ff && !run_ff)
    else $error("Suspend left pins driven.");

  a_susp_mode: assert property (@(posedge clk) disable iff (rst) // R9
    susp_s |=> mode_ff == RSP_SUSPEND)
    else $error("Suspend did not outrank the resets.");

  // Running drives the pins and holds the selects until a new request.
  a_run_drives: assert property (@(posedge clk) disable iff (rst) // R13
    !glb_s && !bus_s && !susp_s |=> oe_ff && run_ff)
    else $error("Block not running with all resets released.");

  a_sel_hold_run: assert property (@(posedge clk) disable iff (rst) // R1
    !glb_s && !bus_s && !susp_s && !sel_req_valid |=> $stable(sel_ff))
    else $error("Selects changed without a request.");

  // Wake context is set while running and untouched by a bare bus reset.
  a_wake_ctx_set: assert property (@(posedge clk) disable iff (rst) // R13
    pme_event_in && !glb_s && !bus_s && !susp_s |=> pme_ff)
    else $error("Wake event not recorded while running.");

  a_bus_keeps_ctx: assert property (@(posedge clk) disable iff (rst) // R11
    bus_s && !glb_s |=> $stable(pme_ff))
    else $error("Bus reset disturbed the wake context.");

  a_susp_no_load: assert property (@(posedge clk) disable iff (rst) // R8
    susp_s && sel_req_valid |=> $stable(sel_ff))
    else $error("Select loaded while suspended.");

endmodule
`default_nettype wire

// >>> rsp_sys_model.sv
// System reset source model that drives the global and bus reset pins.
`timescale 1ns/1ps
`default_nettype none
module rsp_sys_model (
  input  wire logic clk,
  input  wire logic boot,
  input  wire logic bus_rst,
  input  wire logic tied,
  output var  logic global_reset_in,
  output var  logic host_bus_reset_in
);
  // Global reset comes only at boot, or follows bus reset when the pins are tied.
  always_ff @(posedge clk) begin
    global_reset_in   <= boot | (tied & bus_rst);
    host_bus_reset_in <= bus_rst | (tied & boot);
  end
endmodule
`default_nettype wire

// >>> rsp_ctl_test.sv
// Self-checking bench for the reset, suspend and power-select block.
`timescale 1ns/1ps
`default_nettype none
module rsp_ctl_test;
  import rsp_pkg::*;
  logic     clk, rst, boot, bus_rst, tied, susp, pme, vld;
  rsp_sel_t req;
  logic     g_rst, b_rst, c0, c1, p0, p1, oe, ctx, ctx_oe, run;
  int       miscompares = 0;
  int       tests_run = 0;
  rsp_sys_model sys_u (.clk(clk), .boot(boot), .bus_rst(bus_rst), .tied(tied),
    .global_reset_in(g_rst), .host_bus_reset_in(b_rst));
  rsp_ctl dut_u (.clk(clk), .rst(rst), .global_reset_in(g_rst),
    .host_bus_reset_in(b_rst), .suspend_in(susp), .pme_event_in(pme),
    .sel_req_valid(vld), .sel_req(req), .card_supply_sel0(c0),
    .card_supply_sel1(c1), .prog_supply_sel0(p0), .prog_supply_sel1(p1),
    .supply_sel_oe(oe), .pme_context(ctx), .pme_context_oe(ctx_oe), .running(run));
  // Clock at 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compares the whole output picture: enables, running, context, then selects.
  task automatic chk(input string what, input logic [7:0] exp);
    logic [7:0] got;
    got = {oe, ctx_oe, run, ctx, c1, c0, p1, p0};
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  // Waits n edges and lets their updates land.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Presents one select request at a rising edge.
  task automatic load(input rsp_sel_t v);
    @(posedge clk);
    vld <= 1'b1;
    req <= v;
  endtask
  // Pulses the wake event for one cycle.
  task automatic wake();
    @(posedge clk) pme <= 1'b1;
    @(posedge clk) pme <= 1'b0;
  endtask
  task automatic t_sel();
    load(4'hA);
    load(4'h5);
    #1 chk("sel first", 8'hEA);
    @(posedge clk) vld <= 1'b0;
    #1 chk("sel second", 8'hE5);
    $display("t_sel done");
  endtask
  task automatic t_bus();
    wake();
    #1 chk("wake", 8'hF5);
    @(posedge clk) bus_rst <= 1'b1;
    step(5);
    chk("bus held", 8'h10);
    load(4'hF);
    @(posedge clk) vld <= 1'b0;
    step(1);
    chk("bus no load", 8'h10);
    @(posedge clk) bus_rst <= 1'b0;
    step(5);
    chk("bus after", 8'hF0);
    $display("t_bus done");
  endtask
  task automatic t_glob();
    load(4'h6);
    @(posedge clk) vld <= 1'b0;
    #1 chk("glob pre", 8'hF6);
    @(posedge clk) boot <= 1'b1;
    step(5);
    chk("glob held", 8'h00);
    @(posedge clk) boot <= 1'b0;
    step(5);
    chk("glob after", 8'hE0);
    wake();
    @(posedge clk) tied <= 1'b1;
    bus_rst <= 1'b1;
    @(posedge clk) bus_rst <= 1'b0;
    step(5);
    chk("tied resets", 8'hE0);
    $display("t_glob done");
  endtask
  task automatic t_susp();
    wake();
    load(4'h9);
    @(posedge clk) vld <= 1'b0;
    susp <= 1'b1;
    step(5);
    chk("susp float", 8'h19);
    load(4'h3);
    @(posedge clk) vld <= 1'b0;
    @(posedge clk) boot <= 1'b1;
    bus_rst <= 1'b1;
    step(6);
    chk("susp shield", 8'h19);
    @(posedge clk) boot <= 1'b0;
    bus_rst <= 1'b0;
    step(5);
    @(posedge clk) susp <= 1'b0;
    step(5);
    chk("susp after", 8'hF9);
    $display("t_susp done");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    {rst, boot, bus_rst, tied, susp, pme, vld} = 7'h40;
    req = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    step(2);
    chk("reset default", 8'hE0);
    t_sel();
    t_bus();
    t_glob();
    t_susp();
    end_of_test();
  end
endmodule
`default_nettype wire
